/* File: logic/ddt_counter.sv */
// one down counter with its control, reload and interrupt state
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module ddt_counter
   import ddt_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rst_n,
   input  wire ddt_wr_s wr,
   output ddt_ctrl_s    ctrl,
   output logic [31:0]  count,
   output logic [31:0]  reload,
   output logic         raw_irq,
   output logic         irq
);
   ddt_ctrl_s   ctrl_q;
   logic [31:0] count_q;
   logic [31:0] reload_q;
   logic        load_pend_q;
   logic        halted_q;
   logic        raw_q;
   logic        tick;
   logic        at_zero;
   logic        zero_ev;
   ddt_mode_e   mode;

   ddt_prescale u_pre (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (ctrl_q.run_enable),
      .div_sel (ctrl_q.divider_select),
      .tick    (tick)
   );

   // field by field: the stored struct is narrower than the control word
   function automatic ddt_ctrl_s ctrl_decode(input logic [7:0] w);
      ddt_ctrl_s c;
      c.run_enable        = w[DDT_CB_RUN];
      c.periodic_select   = w[DDT_CB_PER];
      c.irq_mask_enable   = w[DDT_CB_IEN];
      c.divider_select    = w[DDT_CB_DIV_HI:DDT_CB_DIV_LO];
      c.width_select      = w[DDT_CB_WIDTH];
      c.single_run_select = w[DDT_CB_SINGLE];
      return c;
   endfunction

   assign mode = ddt_mode(ctrl_q);
   assign at_zero = ctrl_q.width_select ? (count_q == DDT_LOAD_RST)
                                        : (count_q[15:0] == DDT_HALF_ZERO);
   assign zero_ev = tick && !load_pend_q && !halted_q && at_zero;

   // ****************************************
   // control register
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n)
         ctrl_q <= ctrl_decode(DDT_CTRL_RST);
      else if (wr.ctrl_wr)
         ctrl_q <= ctrl_decode(wr.wdata[7:0]);
   end

   // ****************************************
   // reload value, last write of either port wins
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n)
         reload_q <= DDT_LOAD_RST;
      else if (wr.load_wr || wr.bgload_wr)
         reload_q <= wr.wdata;
   end

   // a direct load waits for the next count tick; a deferred one never does
   always_ff @(posedge clk) begin
      if (!rst_n)
         load_pend_q <= 1'b0;
      else if (wr.load_wr)
         load_pend_q <= 1'b1;
      else if (wr.bgload_wr)
         load_pend_q <= 1'b0;
      else if (tick)
         load_pend_q <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         halted_q <= 1'b0;
      else if (tick && load_pend_q)
         halted_q <= 1'b0;
      else if (zero_ev && mode == DDT_SINGLE)
         halted_q <= 1'b1;
   end

   // ****************************************
   // the count itself
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n)
         count_q <= DDT_COUNT_RST;
      else if (tick) begin
         if (load_pend_q)
            count_q <= reload_q;
         else if (halted_q)
            count_q <= count_q;
         else if (zero_ev) begin
            case (mode)
               DDT_PERIOD: count_q <= reload_q;
               DDT_SINGLE: count_q <= count_q;
               default: begin
                  if (ctrl_q.width_select)
                     count_q <= DDT_COUNT_RST;
                  else
                     count_q[15:0] <= DDT_HALF_ONES;
               end
            endcase
         end else if (ctrl_q.width_select)
            count_q <= count_q - 32'h0000_0001;
         else
            count_q[15:0] <= count_q[15:0] - 16'h0001;
      end
   end

   // ****************************************
   // interrupt, set beats a coinciding clear
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n)
         raw_q <= 1'b0;
      else if (zero_ev)
         raw_q <= 1'b1;
      else if (wr.iclr_wr)
         raw_q <= 1'b0;
   end

   assign ctrl    = ctrl_q;
   assign count   = count_q;
   assign reload  = reload_q;
   assign raw_irq = raw_q;
   assign irq     = raw_q && ctrl_q.irq_mask_enable;

   // ****************************************
   // checks
   // ****************************************
   sequence s_zero_hit;
      zero_ev;
   endsequence

   a_raw_set_zero: assert property (@(posedge clk) disable iff (!rst_n)
      s_zero_hit |=> raw_q)
      else $error("raw flag not set after zero");

   a_clear_drops: assert property (@(posedge clk) disable iff (!rst_n)
      (wr.iclr_wr && !zero_ev) |=> !raw_q)
      else $error("clear did not drop raw flag");

   a_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
      (s_zero_hit and ctrl_q.irq_mask_enable and !wr.ctrl_wr) |=> irq)
      else $error("irq not raised with mask on");

   a_hold_stopped: assert property (@(posedge clk) disable iff (!rst_n)
      (!ctrl_q.run_enable && !wr.ctrl_wr) |=> $stable(count_q))
      else $error("count moved while disabled");

   a_period_reload: assert property (@(posedge clk) disable iff (!rst_n)
      (s_zero_hit and mode == DDT_PERIOD) |=> count_q == $past(reload_q))
      else $error("periodic reload missing");

   a_free_wrap: assert property (@(posedge clk) disable iff (!rst_n)
      (s_zero_hit and mode == DDT_FREE and ctrl_q.width_select)
      |=> count_q == DDT_COUNT_RST)
      else $error("free 32-bit wrap wrong");

   a_half_upper: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && !ctrl_q.width_select && !load_pend_q)
      |=> count_q[31:16] == $past(count_q[31:16]))
      else $error("upper half changed in 16-bit mode");

   a_load_next: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && load_pend_q) |=> count_q == $past(reload_q))
      else $error("direct load not applied at tick");

   a_single_stop: assert property (@(posedge clk) disable iff (!rst_n)
      (s_zero_hit and mode == DDT_SINGLE) |=> halted_q)
      else $error("one-shot did not halt");

   a_step_one: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && !load_pend_q && !halted_q && !at_zero && ctrl_q.width_select)
      |=> count_q == $past(count_q) - 32'h0000_0001)
      else $error("count did not step by one");
endmodule // ddt_counter

/* File: logic/ddt_pkg.sv */
// package: register map, control field layout and types for the dual timer
package ddt_pkg;
   // ****************************************
   // register map, one aligned word each
   // ****************************************
   localparam logic [7:0] DDT_OFS_LOAD    = 8'h00;
   localparam logic [7:0] DDT_OFS_VALUE   = 8'h04;
   localparam logic [7:0] DDT_OFS_CTRL    = 8'h08;
   localparam logic [7:0] DDT_OFS_ICLR    = 8'h0C;
   localparam logic [7:0] DDT_OFS_RIS     = 8'h10;
   localparam logic [7:0] DDT_OFS_MIS     = 8'h14;
   localparam logic [7:0] DDT_OFS_BGLOAD  = 8'h18;
   localparam logic [7:0] DDT_OFS_T2_BASE = 8'h20;
   localparam int         DDT_SEL_BIT     = 5;
   // ****************************************
   // control field positions and reset values
   // ****************************************
   localparam int DDT_CB_RUN    = 7;
   localparam int DDT_CB_PER    = 6;
   localparam int DDT_CB_IEN    = 5;
   localparam int DDT_CB_DIV_HI = 3;
   localparam int DDT_CB_DIV_LO = 2;
   localparam int DDT_CB_WIDTH  = 1;
   localparam int DDT_CB_SINGLE = 0;
   localparam logic [7:0]  DDT_CTRL_RST  = 8'h20;
   localparam logic [31:0] DDT_LOAD_RST  = 32'h0000_0000;
   localparam logic [31:0] DDT_COUNT_RST = 32'hFFFF_FFFF;
   localparam logic [15:0] DDT_HALF_ONES = 16'hFFFF;
   localparam logic [15:0] DDT_HALF_ZERO = 16'h0000;
   // ****************************************
   // prescaler codes and terminal counts
   // ****************************************
   localparam logic [1:0] DDT_DIV1   = 2'h0;
   localparam logic [1:0] DDT_DIV16  = 2'h1;
   localparam logic [1:0] DDT_DIV256 = 2'h2;
   localparam logic [7:0] DDT_TC16   = 8'h0F;
   localparam logic [7:0] DDT_TC256  = 8'hFF;

   typedef struct packed {
      logic       run_enable;
      logic       periodic_select;
      logic       irq_mask_enable;
      logic [1:0] divider_select;
      logic       width_select;
      logic       single_run_select;
   } ddt_ctrl_s;

   typedef struct packed {
      logic        load_wr;
      logic        bgload_wr;
      logic        ctrl_wr;
      logic        iclr_wr;
      logic [31:0] wdata;
   } ddt_wr_s;

   typedef enum logic [1:0] {
      DDT_FREE   = 2'b00,
      DDT_PERIOD = 2'b01,
      DDT_SINGLE = 2'b11
   } ddt_mode_e;

   function automatic ddt_mode_e ddt_mode(input ddt_ctrl_s c);
      if (c.single_run_select)
         return DDT_SINGLE;
      else if (c.periodic_select)
         return DDT_PERIOD;
      else
         return DDT_FREE;
   endfunction
endpackage

/* File: logic/ddt_prescale.sv */
// prescaler: divides the count clock by 1, 16 or 256 into a tick
`timescale 1ns/1ps
module ddt_prescale
   import ddt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [1:0] div_sel,
   output logic            tick
);
   logic [7:0] cnt_q;
   logic [7:0] tc;

   always_comb begin
      case (div_sel)
         DDT_DIV16:  tc = DDT_TC16;
         DDT_DIV256: tc = DDT_TC256;
         default:    tc = 8'h00; // reserved code behaves as divide by 1
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !run || cnt_q >= tc)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_q + 8'h01;
   end

   assign tick = run && (cnt_q >= tc);
endmodule // ddt_prescale

/* File: logic/ddt_top.sv */
// top: APB slave and two down counters sharing one count clock
`timescale 1ns/1ps
module ddt_top
   import ddt_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESETN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             IRQ_ONE,
   output logic             IRQ_TWO
);
   // ****************************************
   // bus decode
   // ****************************************
   logic        access;
   logic [7:0]  ofs;
   logic        sel2;
   logic        mapped;
   ddt_wr_s     wr     [2];
   ddt_ctrl_s   ctrl   [2];
   logic [31:0] count  [2];
   logic [31:0] reload [2];
   logic [1:0]  raw;
   logic [1:0]  irq;
   logic [31:0] rd_d;
   logic [31:0] prdata_q;

   assign access = PSEL && PENABLE; // write takes effect in access phase
   assign sel2   = PADDR[DDT_SEL_BIT];
   assign ofs    = PADDR & ~DDT_OFS_T2_BASE;
   assign mapped = (PADDR[1:0] == 2'h0) && (ofs <= DDT_OFS_BGLOAD);

   // ****************************************
   // counters
   // ****************************************
   for (genvar i = 0; i < 2; i++) begin : g_cnt
      logic hit;
      assign hit = access && PWRITE && mapped && (sel2 == 1'(i));
      assign wr[i] = '{load_wr:   hit && ofs == DDT_OFS_LOAD,
                       bgload_wr: hit && ofs == DDT_OFS_BGLOAD,
                       ctrl_wr:   hit && ofs == DDT_OFS_CTRL,
                       iclr_wr:   hit && ofs == DDT_OFS_ICLR,
                       wdata:     PWDATA};
      ddt_counter u_cnt (
         .clk     (CLK_SYS),
         .rst_n   (RESETN),
         .wr      (wr[i]),
         .ctrl    (ctrl[i]),
         .count   (count[i]),
         .reload  (reload[i]),
         .raw_irq (raw[i]),
         .irq     (irq[i])
      );
   end

   // ****************************************
   // read mux, registered so data is stable in access phase
   // ****************************************
   always_comb begin
      logic i;
      i    = sel2;
      rd_d = 32'h0000_0000;
      if (mapped) begin
         case (ofs)
            DDT_OFS_LOAD,
            DDT_OFS_BGLOAD: rd_d = reload[i];
            DDT_OFS_VALUE:  rd_d = count[i];
            DDT_OFS_CTRL:   rd_d = {24'h00_0000, ctrl[i][6:4], 1'b0,
                                    ctrl[i][3:0]};
            DDT_OFS_RIS:    rd_d = {31'h0, raw[i]};
            DDT_OFS_MIS:    rd_d = {31'h0, irq[i]};
            default:        rd_d = 32'h0000_0000;
         endcase
      end
   end

   // setup-phase capture costs nothing: reads never have side effects
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN)
         prdata_q <= 32'h0000_0000;
      else if (PSEL && !PENABLE && !PWRITE)
         prdata_q <= rd_d;
   end

   assign PRDATA  = prdata_q;
   assign PREADY  = 1'b1;
   assign PSLVERR = access && !mapped;
   assign IRQ_ONE = irq[0];
   assign IRQ_TWO = irq[1];

   a_unmapped_err: assert property (
      @(posedge CLK_SYS) disable iff (!RESETN)
      (access && PADDR[1:0] != 2'h0) |-> PSLVERR)
      else $error("misaligned access not flagged");
endmodule // ddt_top

/* File: tb/test_dual_down_counter_timer.sv */
// testbench: registers, modes, prescaler and interrupts of the dual timer
`timescale 1ns/1ps
module test_dual_down_counter_timer
   import ddt_pkg::*;
;
   // ****************************************
   // signals and bookkeeping
   // ****************************************
   typedef struct {
      string       nm;
      logic [31:0] exp;
      logic [31:0] msk;
      logic        err;
      logic [1:0]  im;
      logic [1:0]  ie;
   } ddt_note_s;
   localparam logic [7:0] t2 = DDT_OFS_T2_BASE;
   localparam logic [7:0] ld = DDT_OFS_LOAD;
   localparam logic [7:0] vl = DDT_OFS_VALUE;
   localparam logic [7:0] ct = DDT_OFS_CTRL;
   localparam logic [7:0] ic = DDT_OFS_ICLR;
   localparam logic [7:0] ri = DDT_OFS_RIS;
   localparam logic [7:0] mi = DDT_OFS_MIS;
   localparam logic [7:0] bg = DDT_OFS_BGLOAD;
   logic        clk_sys = 1'b0;
   logic        resetn  = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq_one;
   logic        irq_two;
   logic [1:0]  irq_p   = 2'b00;
   int          err_total = 0;
   int          compares  = 0;
   int          cyc       = 0;
   int          seed      = 93021;
   int          last[2]   = '{-1, -1};
   int          divs[4]   = '{1, 16, 256, 1};
   logic [31:0] iq[2][$];
   ddt_note_s   nq[$];

   ddt_top DUT (
      .CLK_SYS (clk_sys),
      .RESETN  (resetn),
      .PSEL    (psel),
      .PENABLE (penable),
      .PWRITE  (pwrite),
      .PADDR   (paddr),
      .PWDATA  (pwdata),
      .PRDATA  (prdata),
      .PREADY  (pready),
      .PSLVERR (pslverr),
      .IRQ_ONE (irq_one),
      .IRQ_TWO (irq_two)
   );

   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task check(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task tally_and_finish;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // master holds the request until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input string nm, input logic [7:0] a, input logic [31:0] e,
           input logic [31:0] m = 32'hFFFF_FFFF, input logic er = 1'b0,
           input logic [1:0] im = 2'b00, input logic [1:0] ie = 2'b00);
      ddt_note_s n;
      n = '{nm, e, m, er, im, ie};
      nq.push_back(n);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   task wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // first rise after enable only arms the interval stamp
   task start(input int c, input logic [31:0] cw, input logic [31:0] n,
              input int k, input logic [31:0] iv);
      logic [7:0] b;
      b = (c == 1) ? t2 : 8'h00;
      wr(b + ct, 32'h0000_0020);
      wr(b + ld, n);
      wr(b + ic, 32'h0000_0000);
      last[c] = -1;
      repeat (k) iq[c].push_back(iv);
      wr(b + ct, cw);
   endtask

   task drain;
      while (iq[0].size() > 0 || iq[1].size() > 0) begin
         if (irq_one === 1'b1) wr(ic, 32'h0000_0000);
         else if (irq_two === 1'b1) wr(t2 + ic, 32'h0000_0000);
         else @(posedge clk_sys);
      end
   endtask

   // ****************************************
   // watcher: read notes and interrupt spacing
   // ****************************************
   always @(posedge clk_sys) begin : watch
      ddt_note_s  n;
      logic [1:0] q;
      q = {irq_two, irq_one};
      if (psel && penable && !pwrite && pready === 1'b1 && nq.size() > 0) begin
         n = nq.pop_front();
         check(n.nm, prdata & n.msk, n.exp);
         check("pslverr", {31'h0, pslverr}, {31'h0, n.err});
         check("irq", {30'h0, q & n.im}, {30'h0, n.ie});
      end
      for (int c = 0; c < 2; c++) begin
         if (q[c] === 1'b1 && irq_p[c] !== 1'b1) begin
            if (last[c] >= 0 && iq[c].size() > 0)
               check("interval", cyc - last[c], iq[c].pop_front());
            last[c] = cyc;
         end
      end
      irq_p = q;
   end

   // cuts a hang short
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         err_total++;
         tally_and_finish;
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin : main
      logic [31:0] v;
      logic [31:0] w;
      logic [31:0] n;
      wt(4);
      resetn <= 1'b1;
      wt(1);
      for (int c = 0; c < 2; c++) begin
         v = (c == 1) ? 32'h0000_0020 : 32'h0000_0000;
         rd("ctrl", v[7:0] + ct, 32'h0000_0020);
         rd("load", v[7:0] + ld, DDT_LOAD_RST);
         rd("value", v[7:0] + vl, DDT_COUNT_RST);
         rd("ris", v[7:0] + ri, 32'h0, 32'h1, 1'b0, 2'b11, 2'b00);
         rd("mis", v[7:0] + mi, 32'h0, 32'h1);
      end
      $display("test reset values done");
      v = $random(seed);
      w = $random(seed);
      wr(ld, v);
      wr(t2 + bg, w);
      rd("bg_mirror", bg, v);
      rd("ld_mirror", t2 + ld, w);
      rd("ld_kept", ld, v);
      wr(t2 + ct, 32'h0000_00FF);
      rd("fields", t2 + ct, 32'h0000_00EF);
      wr(t2 + ct, 32'h0000_0020);
      rd("gap", 8'h1C, 32'h0, 32'hFFFF_FFFF, 1'b1);
      rd("unmapped", 8'h40, 32'h0, 32'hFFFF_FFFF, 1'b1);
      rd("misalign", 8'h02, 32'h0, 32'hFFFF_FFFF, 1'b1);
      $display("test register access done");
      for (int d = 0; d < 4; d++) begin
         n = (d == 1) ? 3 : (d == 2) ? 1 : (d == 3) ? 19 : 20 + ($random(seed) & 15);
         start(0, 32'hE0 | {28'h0, d[1:0], 2'h0}, n, 2, (n + 1) * divs[d]);
         start(1, 32'h0000_00E2, 32'd30, 2, 32'd31);
         drain;
      end
      start(1, 32'h0000_00E4, 32'h0005_0003, 2, 32'd64);
      drain;
      $display("test periodic and prescaler done");
      start(1, 32'h0000_00C0, 32'd20, 0, 32'd0);
      wt(30);
      rd("ris_m", t2 + ri, 32'h1, 32'h1, 1'b0, 2'b10, 2'b00);
      rd("mis_m", t2 + mi, 32'h0, 32'h1);
      wr(t2 + ct, 32'h0000_00E0);
      rd("mis_on", t2 + mi, 32'h1, 32'h1, 1'b0, 2'b10, 2'b10);
      wr(t2 + ct, 32'h0000_0020);
      wr(t2 + ic, 32'h0000_0000);
      rd("ris_clr", t2 + ri, 32'h0, 32'h1);
      $display("test masking done");
      start(0, 32'h0000_00A3, 32'd5, 0, 32'd0);
      wt(20);
      rd("os_value", vl, 32'h0);
      rd("os_ris", ri, 32'h1, 32'h1, 1'b0, 2'b01, 2'b01);
      wr(ic, 32'h0000_0000);
      wt(20);
      rd("os_halt", ri, 32'h0, 32'h1);
      wr(ld, 32'd7);
      wt(20);
      rd("os_again", ri, 32'h1, 32'h1);
      wr(ic, 32'h0000_0000);
      wr(ld, 32'h0);
      wt(6);
      rd("zero_load", ri, 32'h1, 32'h1);
      start(1, 32'h0000_00A1, 32'h0007_0004, 0, 32'd0);
      wt(20);
      rd("os16", t2 + vl, 32'h0007_0000);
      start(0, 32'h0000_00A3, 32'd80, 0, 32'd0);
      wt(50);
      wr(ct, 32'h0000_0023);
      wt(200);
      rd("frozen", ri, 32'h0, 32'h1);
      wr(ct, 32'h0000_00A3);
      wt(40);
      rd("resumed", ri, 32'h1, 32'h1);
      $display("test one-shot and hold done");
      start(0, 32'h0000_00E2, 32'd1000, 0, 32'd0);
      wt(20);
      wr(ld, 32'd5);
      wt(12);
      rd("load_now", ri, 32'h1, 32'h1);
      start(0, 32'h0000_00E2, 32'd100, 0, 32'd0);
      wt(10);
      wr(bg, 32'd9);
      wt(40);
      rd("bg_keep", ri, 32'h0, 32'h1);
      rd("bg_load", ld, 32'd9);
      last[0] = -1;
      repeat (2) iq[0].push_back(32'd10);
      drain;
      $display("test running loads done");
      start(0, 32'h0000_00A2, 32'd3, 0, 32'd0);
      wt(20);
      wr(ct, 32'h0000_0022);
      rd("wrap32", vl, 32'hFFFF_0000, 32'hFFFF_0000);
      rd("wrap32_ris", ri, 32'h1, 32'h1);
      start(1, 32'h0000_00A0, 32'd5, 1, 32'd65536);
      drain;
      $display("test free running done");
      tally_and_finish;
   end
endmodule // test_dual_down_counter_timer
